// ---- rtl/pidsr_regs.vh ----
// pid speed regulator: register indexes, control fields, codes, scales, timing
// assumes inclusion by the regulator top, checker and bench; holds definitions and nothing else
`ifndef PIDSR_REGS_VH
`define PIDSR_REGS_VH
////////////////////////////////////////////////////////////////////////////////
// register word indexes
`define PIDSR_CTRL      5'h00
`define PIDSR_FBGAIN    5'h01
`define PIDSR_KP        5'h02
`define PIDSR_TI        5'h03
`define PIDSR_TD        5'h04
`define PIDSR_OFS       5'h05
`define PIDSR_LAG       5'h06
`define PIDSR_LOSS_LVL  5'h07
`define PIDSR_LOSS_DLY  5'h08
`define PIDSR_ILIM      5'h09
`define PIDSR_IRST_TIME 5'h0a
`define PIDSR_IRST_TOL  5'h0b
`define PIDSR_SLP_LVL   5'h0c
`define PIDSR_SLP_DLY   5'h0d
`define PIDSR_WAK_LVL   5'h0e
`define PIDSR_WAK_DLY   5'h0f
`define PIDSR_FB_MAX    5'h10
`define PIDSR_FB_MIN    5'h11
`define PIDSR_KEY_TGT   5'h12
`define PIDSR_FMAX      5'h13
`define PIDSR_STATUS    5'h14
`define PIDSR_PID_OUT   5'h15
`define PIDSR_FB_DISP   5'h16
`define PIDSR_SPARE     5'h17
`define PIDSR_PRESET0   5'h18
////////////////////////////////////////////////////////////////////////////////
// control register fields
`define PIDSR_F_MODE    3:0
`define PIDSR_F_TSRC    6:4
`define PIDSR_F_FSRC    8:7
`define PIDSR_F_OFSNEG  9
`define PIDSR_F_LOSS    11:10
////////////////////////////////////////////////////////////////////////////////
// codes
`define PIDSR_FREQSEL_PID 3'h6
`define PIDSR_TSRC_POT    3'h0
`define PIDSR_TSRC_VOLT   3'h1
`define PIDSR_TSRC_CURR   3'h2
`define PIDSR_TSRC_COMM   3'h3
`define PIDSR_TSRC_KEY    3'h4
`define PIDSR_TSRC_PRESET 3'h5
`define PIDSR_FBSRC_POT   2'h0
`define PIDSR_FBSRC_VOLT  2'h1
`define PIDSR_FBSRC_CURR  2'h2
`define PIDSR_FBSRC_COMM  2'h3
`define PIDSR_MODE_OFF    4'h0
`define PIDSR_MODE_ADD    4'h5
`define PIDSR_MODE_MAX    4'h8
`define PIDSR_LOSS_OFF    2'h0
`define PIDSR_LOSS_STOP   2'h2
////////////////////////////////////////////////////////////////////////////////
// reset values
`define PIDSR_FBGAIN_RST  16'h0064
`define PIDSR_FMAX_RST    16'h1770
`define PIDSR_FBMAX_RST   16'h03e7
////////////////////////////////////////////////////////////////////////////////
// arithmetic scales (full scale 8192 = 100 percent)
`define PIDSR_FULL        48'sh2000
`define PIDSR_CENT        48'sh64
`define PIDSR_MILLE       48'sh3e8
`define PIDSR_TEN         48'sha
`define PIDSR_OUT_MAX     48'shffff
////////////////////////////////////////////////////////////////////////////////
// timing: clock period, sample tick, tenth of a second, all in ns; tenths per second as a plain count
`define PIDSR_CLK_NS      32'h00000064
`define PIDSR_TICK_NS     32'h000f4240
`define PIDSR_TENTH_NS    32'h05f5e100
`define PIDSR_SEC_TENTHS  32'h0000000a
`endif

// ---- rtl/pidsr_dly.v ----
// pid speed regulator: qualifying delay timer counted in sample ticks
// assumes one clock, async active-low reset, tick one cycle wide
module pidsr_dly #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // timing
  input  wire         tick,
  input  wire         cond,
  input  wire [W-1:0] limit,
  // result
  output reg          done_r
);

  reg [W-1:0] cnt_r;

  // count while the condition holds; any drop restarts the wait
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= {W{1'b0}};
      done_r <= 1'b0;
    end else if (!cond) begin
      cnt_r  <= {W{1'b0}};
      done_r <= 1'b0;
    end else begin
      if (tick && (cnt_r < limit))
        cnt_r <= cnt_r + 1'b1;  // saturates at the limit
      done_r <= (cnt_r >= limit);
    end
  end

endmodule // pidsr_dly

// ---- rtl/pidsr_top.v ----
// pid speed regulator: target/feedback select, pid terms, loss, reset, sleep
// assumes sources sampled on CLK, register port with read data one cycle later
// Operation
// [RL1] target and feedback selections act only when frequency source code is 6
// [RL2] target code 5 takes the target from the preset table
// [RL3] three multispeed inputs form binary preset index, bit0 least significant
// [RL4] software never sets feedback source equal to target source code
// [RL5] odd modes: derivative acts on deviation over derivative unit time
// [RL6] even modes: derivative acts on feedback only; mode 0 disables
// [RL7] modes 1,2 direct acting; modes 3,4 reverse acting
// [RL8] modes 5 to 8 add regulator result to ordinary frequency command
// [RL9] deviation is target minus feedback times gain 0.00 to 10.00
// [RL10] proportional, integral and derivative gains form the three terms
// [RL11] output shifted by offset 0 to 109 percent, sign from polarity bit
// [RL12] first-order lag filter with time constant 0.0 to 2.5
// [RL13] loss mode: 0 ignore, 1 run and flag, 2 stop and flag
// [RL14] loss when error exceeds level continuously for the loss delay
// [RL15] integrator clamped to limit 0 to 109 percent
// [RL16] on target reached, integrator clears after set seconds and drive stops
// [RL17] restart after clear only when deviation exceeds tolerance
// [RL18] output below sleep level longer than sleep delay enters sleep
// [RL19] while asleep, output above wake level resumes regulation
// [RL20] feedback max and min rescale feedback for display only
// [RL21] wake needs output above wake level longer than wake delay
// [RL22] terms, timers and filter update once per sample tick
`include "pidsr_regs.vh"
module pidsr_top #(
  parameter [31:0] TICK_CYC = `PIDSR_TICK_NS / `PIDSR_CLK_NS,
  parameter [31:0] TPT      = `PIDSR_TENTH_NS / `PIDSR_TICK_NS
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // register port
  input  wire [4:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // drive context
  input  wire [2:0]  FREQ_SRC_SEL,
  input  wire [15:0] FREQ_CMD,
  // signal sources
  input  wire [15:0] KEYPAD_POT,
  input  wire [15:0] VOLTAGE_ANALOG_INPUT,
  input  wire [15:0] CURRENT_ANALOG_INPUT,
  input  wire [15:0] COMM_VALUE,
  input  wire        MULTISPEED_INPUT_BIT0,
  input  wire        MULTISPEED_INPUT_BIT1,
  input  wire        MULTISPEED_INPUT_BIT2,
  // drive outputs
  output reg  [15:0] OUT_FREQ,
  output reg         DRIVE_RUN_EN,
  output reg         FEEDBACK_LOSS_INDICATION,
  output reg         SLEEP_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function signed [47:0] u2s;
    input [31:0] v;
    u2s = {16'h0000, v};
  endfunction

  function signed [47:0] clampf;
    input signed [47:0] v;
    input signed [47:0] lo;
    input signed [47:0] hi;
    clampf = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  reg [15:0] cfg_r [0:31];
  reg [31:0] tick_cnt_r;
  reg        tick_r;
  reg signed [47:0] acc_r;
  reg signed [47:0] xprev_r;
  reg signed [47:0] y_r;
  reg        hold_r;
  reg        sleep_r;
  reg [15:0] pid_hz_r;
  reg [15:0] fb_disp_r;
  reg [15:0] rd_mux;
  integer    i;

  wire loss_done;
  wire irst_done;
  wire slp_done;
  wire wak_done;

  ////////////////////////////////////////////////////////////////////////////
  // sample tick: one pulse every TICK_CYC clocks
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_r <= 32'h00000000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYC - 32'h1) begin
      tick_cnt_r <= 32'h00000000;
      tick_r     <= 1'b1;                                  // [RL22]
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  wire [15:0] ctrl      = cfg_r[`PIDSR_CTRL];
  wire [3:0]  mode      = ctrl[`PIDSR_F_MODE];
  wire [2:0]  tsrc      = ctrl[`PIDSR_F_TSRC];
  wire [1:0]  fsrc      = ctrl[`PIDSR_F_FSRC];
  wire        ofs_neg   = ctrl[`PIDSR_F_OFSNEG];
  wire [1:0]  loss_mode = ctrl[`PIDSR_F_LOSS];
  // selections only count with the pid chosen as frequency source
  wire pid_on  = (FREQ_SRC_SEL == `PIDSR_FREQSEL_PID) &&          // [RL1]
                 (mode != `PIDSR_MODE_OFF) && (mode <= `PIDSR_MODE_MAX); // [RL6]
  wire reverse = (mode == 4'h3) || (mode == 4'h4) ||
                 (mode == 4'h7) || (mode == 4'h8);                // [RL7]
  wire d_on_fb = ~mode[0];                                        // [RL6]
  wire add_cmd = (mode >= `PIDSR_MODE_ADD);                       // [RL8]
  wire [2:0] ms_idx = {MULTISPEED_INPUT_BIT2, MULTISPEED_INPUT_BIT1,
                       MULTISPEED_INPUT_BIT0};                    // [RL3]
  wire [4:0] pre_idx = `PIDSR_PRESET0 + {2'b00, ms_idx};

  ////////////////////////////////////////////////////////////////////////////
  // target and feedback selection
  reg signed [47:0] tgt;
  reg signed [47:0] fb;
  always @* begin
    case (tsrc)
      `PIDSR_TSRC_POT:    tgt = u2s({16'h0000, KEYPAD_POT});
      `PIDSR_TSRC_VOLT:   tgt = u2s({16'h0000, VOLTAGE_ANALOG_INPUT});
      `PIDSR_TSRC_CURR:   tgt = u2s({16'h0000, CURRENT_ANALOG_INPUT});
      `PIDSR_TSRC_COMM:   tgt = u2s({16'h0000, COMM_VALUE});
      `PIDSR_TSRC_KEY:    tgt = u2s({16'h0000, cfg_r[`PIDSR_KEY_TGT]}) *
                                `PIDSR_FULL / `PIDSR_MILLE;
      `PIDSR_TSRC_PRESET: tgt = u2s({16'h0000, cfg_r[pre_idx]}); // [RL2]
      default:            tgt = 48'sh0;
    endcase
    case (fsrc)
      `PIDSR_FBSRC_POT:  fb = u2s({16'h0000, KEYPAD_POT});
      `PIDSR_FBSRC_VOLT: fb = u2s({16'h0000, VOLTAGE_ANALOG_INPUT});
      `PIDSR_FBSRC_CURR: fb = u2s({16'h0000, CURRENT_ANALOG_INPUT});
      default:           fb = u2s({16'h0000, COMM_VALUE});
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pid arithmetic; a shared source code is software's to avoid   [RL4]
  reg signed [47:0] fbs, dev, err, p_t, i_t, d_t, x_cur, ofs_t, sum;
  reg signed [47:0] ilim, acc_lim, acc_nxt, ti_ticks, lag_ticks, y_nxt;
  reg signed [47:0] hz, out_s, tol, lvl, disp;
  always @* begin
    fbs = fb * u2s({16'h0000, cfg_r[`PIDSR_FBGAIN]}) / `PIDSR_CENT; // [RL9]
    dev = tgt - fbs;                                                // [RL9]
    err = reverse ? -dev : dev;                                     // [RL7]
    p_t = err * u2s({16'h0000, cfg_r[`PIDSR_KP]}) / `PIDSR_TEN;     // [RL10]
    // integrator limited so the i term never exceeds its limit
    ilim     = u2s({16'h0000, cfg_r[`PIDSR_ILIM]}) * `PIDSR_FULL / `PIDSR_CENT;
    ti_ticks = u2s({16'h0000, cfg_r[`PIDSR_TI]}) * u2s(TPT);
    acc_lim  = ilim * ti_ticks;                                     // [RL15]
    acc_nxt  = clampf(acc_r + err, -acc_lim, acc_lim);              // [RL15]
    i_t = (ti_ticks == 48'sh0) ? 48'sh0 : acc_r / ti_ticks;         // [RL10]
    // derivative on deviation, or on feedback with the loop's sign
    x_cur = d_on_fb ? (reverse ? fbs : -fbs) : err;                 // [RL5] [RL6]
    d_t = (x_cur - xprev_r) * u2s({16'h0000, cfg_r[`PIDSR_TD]}) *
          u2s(TPT) / `PIDSR_TEN;                                    // [RL10]
    ofs_t = u2s({16'h0000, cfg_r[`PIDSR_OFS]}) * `PIDSR_FULL / `PIDSR_CENT;
    if (ofs_neg)
      ofs_t = -ofs_t;                                               // [RL11]
    sum = clampf(p_t + i_t + d_t + ofs_t, -`PIDSR_FULL, `PIDSR_FULL); // [RL11]
    // lag filter; zero time constant passes the sum straight through
    lag_ticks = u2s({16'h0000, cfg_r[`PIDSR_LAG]}) * u2s(TPT);
    y_nxt = (lag_ticks == 48'sh0) ? sum :
            y_r + (sum - y_r) / lag_ticks;                          // [RL12]
    hz    = y_r * u2s({16'h0000, cfg_r[`PIDSR_FMAX]}) / `PIDSR_FULL;
    out_s = clampf(hz + (add_cmd ? u2s({16'h0000, FREQ_CMD}) : 48'sh0),
                   48'sh0, `PIDSR_OUT_MAX);                         // [RL8]
    tol = u2s({16'h0000, cfg_r[`PIDSR_IRST_TOL]});                  // [RL17]
    lvl = u2s({16'h0000, cfg_r[`PIDSR_LOSS_LVL]}) * `PIDSR_FULL / `PIDSR_CENT;
    // display only: never fed back into the loop
    disp = u2s({16'h0000, cfg_r[`PIDSR_FB_MIN]}) +
           fb * (u2s({16'h0000, cfg_r[`PIDSR_FB_MAX]}) -
                 u2s({16'h0000, cfg_r[`PIDSR_FB_MIN]})) / `PIDSR_FULL; // [RL20]
  end

  wire [15:0] pid_hz = (hz < 48'sh0) ? 16'h0000 :
                       ((hz > `PIDSR_OUT_MAX) ? 16'hffff : hz[15:0]);
  wire        dev_in  = (dev <= tol) && (dev >= -tol);
  wire        loss_on = (loss_mode != `PIDSR_LOSS_OFF) && loss_done;  // [RL13]
  wire        stop    = sleep_r || hold_r ||
                        (loss_on && (loss_mode == `PIDSR_LOSS_STOP)); // [RL13]

  ////////////////////////////////////////////////////////////////////////////
  // qualifying timers
  wire [31:0] loss_lim = {16'h0000, cfg_r[`PIDSR_LOSS_DLY]} * TPT;
  wire [31:0] irst_lim = {16'h0000, cfg_r[`PIDSR_IRST_TIME]} * TPT * `PIDSR_SEC_TENTHS;
  wire [31:0] slp_lim  = {16'h0000, cfg_r[`PIDSR_SLP_DLY]} * TPT;
  wire [31:0] wak_lim  = {16'h0000, cfg_r[`PIDSR_WAK_DLY]} * TPT;

  pidsr_dly #(.W(32)) u_loss (
    .clk    (CLK),
    .rst_n  (RST_N),
    .tick   (tick_r),
    .cond   (pid_on && (dev > lvl)),                          // [RL14]
    .limit  (loss_lim),
    .done_r (loss_done)
  );

  pidsr_dly #(.W(32)) u_irst (
    .clk    (CLK),
    .rst_n  (RST_N),
    .tick   (tick_r),
    .cond   (pid_on && dev_in && !hold_r &&
             (cfg_r[`PIDSR_IRST_TIME] != 16'h0000)),          // [RL16]
    .limit  (irst_lim),
    .done_r (irst_done)
  );

  pidsr_dly #(.W(32)) u_slp (
    .clk    (CLK),
    .rst_n  (RST_N),
    .tick   (tick_r),
    .cond   (pid_on && !sleep_r && (pid_hz < cfg_r[`PIDSR_SLP_LVL])), // [RL18]
    .limit  (slp_lim),
    .done_r (slp_done)
  );

  pidsr_dly #(.W(32)) u_wak (
    .clk    (CLK),
    .rst_n  (RST_N),
    .tick   (tick_r),
    .cond   (pid_on && sleep_r && (pid_hz > cfg_r[`PIDSR_WAK_LVL])), // [RL19]
    .limit  (wak_lim),
    .done_r (wak_done)                                        // [RL21]
  );

  ////////////////////////////////////////////////////////////////////////////
  // regulator state, advanced once per tick
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_r   <= 48'sh0;
      xprev_r <= 48'sh0;
      y_r     <= 48'sh0;
    end else if (!pid_on) begin
      acc_r   <= 48'sh0;
      xprev_r <= 48'sh0;
      y_r     <= 48'sh0;
    end else if (irst_done || hold_r) begin
      acc_r   <= 48'sh0;                                      // [RL16]
      if (tick_r) begin
        xprev_r <= x_cur;
        y_r     <= y_nxt;
      end
    end else if (tick_r) begin
      acc_r   <= acc_nxt;                                     // [RL22]
      xprev_r <= x_cur;
      y_r     <= y_nxt;                                       // [RL12]
    end
  end

  // hold after integrator clear, sleep flag; both set and cleared by hardware
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_r  <= 1'b0;
      sleep_r <= 1'b0;
    end else if (!pid_on) begin
      hold_r  <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      if (irst_done)
        hold_r <= 1'b1;                                       // [RL16]
      else if (hold_r && !dev_in)
        hold_r <= 1'b0;                                       // [RL17]
      if (slp_done)
        sleep_r <= 1'b1;                                      // [RL18]
      else if (wak_done)
        sleep_r <= 1'b0;                                      // [RL21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive outputs, all registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUT_FREQ                 <= 16'h0000;
      DRIVE_RUN_EN             <= 1'b0;
      FEEDBACK_LOSS_INDICATION <= 1'b0;
      SLEEP_ACTIVE             <= 1'b0;
      pid_hz_r                 <= 16'h0000;
      fb_disp_r                <= 16'h0000;
    end else begin
      // zero on stop lets the drive ramp decelerate to standstill
      if (!pid_on)
        OUT_FREQ <= FREQ_CMD;
      else if (stop)
        OUT_FREQ <= 16'h0000;                                 // [RL18]
      else
        OUT_FREQ <= out_s[15:0];
      DRIVE_RUN_EN             <= !(pid_on && stop);          // [RL16]
      FEEDBACK_LOSS_INDICATION <= pid_on && loss_on;          // [RL13]
      SLEEP_ACTIVE             <= sleep_r;
      pid_hz_r                 <= pid_hz;
      fb_disp_r                <= disp[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port: status words are read only, spare reads zero
  always @* begin
    case (ADDR)
      `PIDSR_STATUS:  rd_mux = {12'h000, hold_r, sleep_r,
                                FEEDBACK_LOSS_INDICATION, DRIVE_RUN_EN};
      `PIDSR_PID_OUT: rd_mux = pid_hz_r;
      `PIDSR_FB_DISP: rd_mux = fb_disp_r;
      `PIDSR_SPARE:   rd_mux = 16'h0000;
      default:        rd_mux = cfg_r[ADDR];
    endcase
  end

  wire wr_ok = WR && ((ADDR < `PIDSR_STATUS) || (ADDR >= `PIDSR_PRESET0));

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (i = 0; i < 32; i = i + 1)
        cfg_r[i] <= 16'h0000;
      cfg_r[`PIDSR_FBGAIN] <= `PIDSR_FBGAIN_RST;
      cfg_r[`PIDSR_FMAX]   <= `PIDSR_FMAX_RST;
      cfg_r[`PIDSR_FB_MAX] <= `PIDSR_FBMAX_RST;
      RDATA                <= 16'h0000;
    end else begin
      if (wr_ok)
        cfg_r[ADDR] <= WDATA;
      RDATA <= RD ? rd_mux : 16'h0000;  // valid only the cycle after RD
    end
  end

endmodule // pidsr_top

// ---- dv/pidsr_chk_asserts.sv ----
// checker for the pid speed regulator: port relations over time
// assumes binding to pidsr_top and that every control write shows on its port
`include "pidsr_regs.vh"
module pidsr_chk (
  // clock and reset
  input wire        CLK,
  input wire        RST_N,
  // register port
  input wire [4:0]  ADDR,
  input wire [15:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [15:0] RDATA,
  // drive side
  input wire [2:0]  FREQ_SRC_SEL,
  input wire [15:0] FREQ_CMD,
  input wire [15:0] OUT_FREQ,
  input wire        DRIVE_RUN_EN,
  input wire        FEEDBACK_LOSS_INDICATION,
  input wire        SLEEP_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [15:0] ctrl_r;
  wire [3:0]  mode_w = ctrl_r[3:0];
  wire [1:0]  loss_w = ctrl_r[11:10];
  wire        on_w   = (FREQ_SRC_SEL == `PIDSR_FREQSEL_PID) && (mode_w != `PIDSR_MODE_OFF)
                       && (mode_w <= `PIDSR_MODE_MAX);
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the control word, the port being the only way in
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= 16'h0000;
    end else if (WR && ADDR == `PIDSR_CTRL) begin
      ctrl_r <= WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // three cycles, since the sleep flag trails the internal state by one
  sequence s_off; !on_w [*3]; endsequence
  sequence s_quiet; (loss_w == `PIDSR_LOSS_OFF) [*3]; endsequence
  property p_off_pass;
    s_off |=> OUT_FREQ == $past(FREQ_CMD) && DRIVE_RUN_EN && !FEEDBACK_LOSS_INDICATION
              && !SLEEP_ACTIVE;
  endproperty
  property p_loss_quiet; s_quiet |=> !FEEDBACK_LOSS_INDICATION; endproperty
  property p_loss_stop;
    FEEDBACK_LOSS_INDICATION && on_w && loss_w == `PIDSR_LOSS_STOP |-> ##[0:2] !DRIVE_RUN_EN;
  endproperty
  property p_stop_cause; $fell(DRIVE_RUN_EN) |-> $past(FREQ_SRC_SEL) == `PIDSR_FREQSEL_PID; endproperty
  property p_sleep_zero; SLEEP_ACTIVE && on_w && mode_w < `PIDSR_MODE_ADD |-> OUT_FREQ == 16'h0000; endproperty
  property p_sleep_cause; $rose(SLEEP_ACTIVE) |-> $past(FREQ_SRC_SEL, 2) == `PIDSR_FREQSEL_PID; endproperty
  property p_rd_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
  property p_spare_rd; $past(RD) && $past(ADDR) == `PIDSR_SPARE |-> RDATA == 16'h0000; endproperty
  a_off_pass: assert property (p_off_pass) else $error("pid off but outputs altered");
  a_loss_quiet: assert property (p_loss_quiet) else $error("loss flag while ignored");
  a_loss_stop: assert property (p_loss_stop) else $error("loss stop did not stop");
  a_stop_cause: assert property (p_stop_cause) else $error("stop while pid not selected");
  a_sleep_zero: assert property (p_sleep_zero) else $error("output not zero asleep");
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep while pid not selected");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  a_spare_rd: assert property (p_spare_rd) else $error("spare word not zero");
endmodule // pidsr_chk

bind pidsr_top pidsr_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .FREQ_SRC_SEL(FREQ_SRC_SEL), .FREQ_CMD(FREQ_CMD), .OUT_FREQ(OUT_FREQ),
  .DRIVE_RUN_EN(DRIVE_RUN_EN), .FEEDBACK_LOSS_INDICATION(FEEDBACK_LOSS_INDICATION),
  .SLEEP_ACTIVE(SLEEP_ACTIVE)
);

// ---- dv/pidsr_src.sv ----
// partner model: feedback transducer and reference sources of the drive
// assumes the bench calls set_src; a value moves just after a rising edge
module pidsr_src (
  // clock
  input  wire        clk,
  // source values, 8192 is full scale
  output reg  [15:0] pot,
  output reg  [15:0] volt,
  output reg  [15:0] curr,
  output reg  [15:0] comm
);
  timeunit 1ns;
  timeprecision 1ns;
  //////////////////////////////////////////////////////////////////////////////
  // zero at start, so no stray target shows before setup
  initial begin
    {pot, volt, curr, comm} = '0;
  end
  // one source per call, then held until the next call
  task set_src(input [1:0] which, input [15:0] val);
    @(posedge clk);
    case (which)
      2'h0: pot <= val;
      2'h1: volt <= val;
      2'h2: curr <= val;
      default: comm <= val;
    endcase
  endtask
endmodule // pidsr_src

// ---- dv/test_pid_speed_regulator.sv ----
// bench for the pid speed regulator: registers, select, terms, loss, sleep
// assumes a 10 clock sample tick and two ticks to a tenth of a second
`include "pidsr_regs.vh"
module test_pid_speed_regulator;
  timeunit 1ns;
  timeprecision 1ns;
  localparam integer FS  = `PIDSR_FMAX_RST;
  localparam integer P50 = 32'h1000 * FS / 32'h2000;
  localparam integer CMD = 32'h0fa0;
  reg         clk, rst_n, wr_s, rd_s;
  reg  [4:0]  addr;
  reg  [15:0] wdata, fcmd;
  reg  [2:0]  fsel, ms;
  wire [15:0] rdata, out_freq, pot, volt, curr, comm;
  wire        run_en, loss_ind, sleep_act;
  integer     fail_count, samples_checked;
  //////////////////////////////////////////////////////////////////////////////
  pidsr_top #(.TICK_CYC(32'h0000000a), .TPT(32'h00000002)) DUT (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .FREQ_SRC_SEL(fsel), .FREQ_CMD(fcmd), .KEYPAD_POT(pot),
    .VOLTAGE_ANALOG_INPUT(volt), .CURRENT_ANALOG_INPUT(curr), .COMM_VALUE(comm),
    .MULTISPEED_INPUT_BIT0(ms[0]), .MULTISPEED_INPUT_BIT1(ms[1]),
    .MULTISPEED_INPUT_BIT2(ms[2]), .OUT_FREQ(out_freq), .DRIVE_RUN_EN(run_en),
    .FEEDBACK_LOSS_INDICATION(loss_ind), .SLEEP_ACTIVE(sleep_act)
  );
  pidsr_src SRC (.clk(clk), .pot(pot), .volt(volt), .curr(curr), .comm(comm));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input [4:0] a, output [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // feedback always from the voltage input, never the target's code
  task cfg(input [3:0] m, input [2:0] ts, input [1:0] ls, input ng);
    wr(`PIDSR_CTRL, {4'h0, ls, ng, 2'h1, ts, m});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    reg [15:0] v;
    rd(`PIDSR_FMAX, v);
    chk("fmax reset", v, `PIDSR_FMAX_RST);
    rd(`PIDSR_FBGAIN, v);
    chk("gain reset", v, `PIDSR_FBGAIN_RST);
    wr(`PIDSR_KP, 16'h0005);
    rd(`PIDSR_KP, v);
    chk("kp", v, 16'h0005);
    wr(`PIDSR_SPARE, 16'hffff);
    rd(`PIDSR_SPARE, v);
    chk("spare", v, 16'h0000);
  endtask
  task t_off;
    cfg(4'h1, 3'h0, 2'h0, 1'b0);
    @(posedge clk);
    fcmd <= 16'h04d2;
    cyc(3);
    chk("off out", out_freq, 16'h04d2);
    chk("off run", 16'(run_en), 16'h0001);
  endtask
  // every mode code 1 to 8, half-scale deviation, plus off codes 0 and 9
  task t_modes;
    integer m;
    integer e;
    @(posedge clk);
    fsel <= `PIDSR_FREQSEL_PID;
    fcmd <= CMD[15:0];
    SRC.set_src(2'h0, 16'h1000);
    wr(`PIDSR_KP, 16'h000a);
    for (m = 0; m <= 9; m = m + 1) begin
      cfg(m[3:0], 3'h0, 2'h0, 1'b0);
      cyc(40);
      e = (((m - 1) % 4) < 2) ? P50 : -P50;
      e = e + ((m > 4) ? CMD : 0);
      if (m == 0 || m == 9) e = CMD;
      chk("mode out", out_freq, (e < 0) ? 16'h0000 : 16'(e));
    end
  endtask
  task t_terms;
    reg [15:0] v;
    cfg(4'h1, 3'h0, 2'h0, 1'b0);
    SRC.set_src(2'h1, 16'h0800);
    wr(`PIDSR_FBGAIN, 16'h0032);
    cyc(40);
    chk("gain half", out_freq, 16'(32'h0c00 * FS / 32'h2000));
    rd(`PIDSR_FB_DISP, v);
    chk("disp", v, 16'h00f9);
    wr(`PIDSR_FBGAIN, 16'h00c8);
    cyc(40);
    chk("gain double", out_freq, 16'h0000);
    wr(`PIDSR_FBGAIN, 16'h0064);
    SRC.set_src(2'h1, 16'h0000);
    wr(`PIDSR_OFS, 16'h0032);
    cyc(40);
    chk("offset up", out_freq, 16'(FS));
    cfg(4'h1, 3'h0, 2'h0, 1'b1);
    cyc(40);
    chk("offset down", out_freq, 16'h0000);
    wr(`PIDSR_OFS, 16'h0000);
  endtask
  // full deviation against a half-scale level, two-tick delay
  task t_loss;
    integer i;
    wr(`PIDSR_LOSS_LVL, 16'h0032);
    wr(`PIDSR_LOSS_DLY, 16'h0001);
    cfg(4'h1, 3'h0, 2'h2, 1'b0);
    SRC.set_src(2'h0, 16'h2000);
    cyc(5);
    chk("loss early", 16'(loss_ind), 16'h0000);
    for (i = 0; i < 60 && loss_ind !== 1'b1; i = i + 1) @(posedge clk);
    cyc(3);
    chk("loss flag", 16'(loss_ind), 16'h0001);
    chk("loss stop", 16'(run_en), 16'h0000);
    cfg(4'h1, 3'h0, 2'h1, 1'b0);
    cyc(3);
    chk("loss run flag", 16'(loss_ind), 16'h0001);
    chk("loss run", 16'(run_en), 16'h0001);
    cfg(4'h1, 3'h0, 2'h0, 1'b0);
    SRC.set_src(2'h0, 16'h1000);
    cyc(3);
    chk("loss off", 16'(loss_ind), 16'h0000);
  endtask
  // only entry five is nonzero, so each index shows whether entry five was used
  task t_preset;
    integer i;
    wr(`PIDSR_PRESET0 + 5'h05, 16'h1000);
    cfg(4'h1, 3'h5, 2'h0, 1'b0);
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk);
      ms <= i[2:0];
      cyc(40);
      chk("preset pick", 16'(out_freq != 16'h0000), 16'(i == 5));
    end
  endtask
  task t_sleep;
    integer i;
    cfg(4'h1, 3'h0, 2'h0, 1'b0);
    SRC.set_src(2'h0, 16'h0000);
    wr(`PIDSR_SLP_LVL, 16'h03e8);
    wr(`PIDSR_SLP_DLY, 16'h0001);
    wr(`PIDSR_WAK_LVL, 16'h07d0);
    wr(`PIDSR_WAK_DLY, 16'h0001);
    for (i = 0; i < 100 && sleep_act !== 1'b1; i = i + 1) @(posedge clk);
    cyc(2);
    chk("asleep", 16'(sleep_act), 16'h0001);
    SRC.set_src(2'h0, 16'h2000);
    cyc(5);
    chk("wake early", 16'(sleep_act), 16'h0001);
    for (i = 0; i < 100 && sleep_act !== 1'b0; i = i + 1) @(posedge clk);
    cyc(40);
    chk("awake", 16'(sleep_act), 16'h0000);
    chk("awake out", out_freq, 16'(FS));
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // all inputs defined at time zero, reset held for ten cycles
  initial begin
    {rst_n, wr_s, rd_s, addr, wdata, fcmd, fsel, ms} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_off;
    t_modes;
    t_terms;
    t_loss;
    t_preset;
    t_sleep;
    finish_test;
  end
  // whole run is near 1100 cycles; this allows about nine times that
  initial begin
    #1000000;
    fail_count = fail_count + 1;
    finish_test;
  end
endmodule // test_pid_speed_regulator
